// ==== logic/ppde_regs.svh ====
`ifndef PPDE_REGS_SVH
`define PPDE_REGS_SVH

// Register indices; each register takes one aligned word at four times its index
`define PPDE_IDX_G 14'h30b6
`define PPDE_IDX_H 14'h30b7
`define PPDE_IDX_A 14'h30b8
`define PPDE_IDX_B 14'h30b9

`define PPDE_ADDR_G {`PPDE_IDX_G, 2'b00}
`define PPDE_ADDR_H {`PPDE_IDX_H, 2'b00}
`define PPDE_ADDR_A {`PPDE_IDX_A, 2'b00}
`define PPDE_ADDR_B {`PPDE_IDX_B, 2'b00}

// Writable bit positions; zeros are reserved and read as zero
`define PPDE_MASK_G 8'h0f
`define PPDE_MASK_H 8'hc7
`define PPDE_MASK_A 8'hef
`define PPDE_MASK_B 8'hff

`define PPDE_RESET_G 8'h00
`define PPDE_RESET_H 8'h00
`define PPDE_RESET_A 8'h00
`define PPDE_RESET_B 8'h00

`define PPDE_RESP_OKAY 2'b00
`define PPDE_RESP_SLVERR 2'b10

`endif

// ==== logic/ppde_pkg.sv ====
`include "ppde_regs.svh"

package ppde_pkg;

	typedef enum logic [4:0] {
		PPDE_SEL_NONE = 5'b00001,
		PPDE_SEL_G = 5'b00010,
		PPDE_SEL_H = 5'b00100,
		PPDE_SEL_A = 5'b01000,
		PPDE_SEL_B = 5'b10000
	} ppde_sel_t;

	typedef enum logic [1:0] {
		PPDE_CH_IDLE = 2'b01,
		PPDE_CH_RESP = 2'b10
	} ppde_ch_state_t;

	// Byte address to register select; anything else is unmapped
	function automatic ppde_sel_t ppde_decode(input logic [15:0] addr);
		ppde_sel_t sel;
		sel = PPDE_SEL_NONE;
		if (addr == `PPDE_ADDR_G)
			sel = PPDE_SEL_G;
		else if (addr == `PPDE_ADDR_H)
			sel = PPDE_SEL_H;
		else if (addr == `PPDE_ADDR_A)
			sel = PPDE_SEL_A;
		else if (addr == `PPDE_ADDR_B)
			sel = PPDE_SEL_B;
		return sel;
	endfunction

endpackage

// ==== logic/ppde_wr_chan.sv ====
`timescale 1ns/1ps
`include "ppde_regs.svh"

module ppde_wr_chan
	import ppde_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Register side
	output logic wr_commit,
	output logic [15:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok
);

	ppde_ch_state_t state, next_state;
	logic have_aw, next_have_aw;
	logic have_w, next_have_w;
	logic [15:0] next_wr_addr;
	logic [31:0] next_wr_data;
	logic [3:0] next_wr_strb;
	logic next_awready, next_wready, next_bvalid;
	logic [1:0] next_bresp;

	// Address and data are held apart until both are in, so either order works
	assign wr_commit = (state == PPDE_CH_IDLE) && have_aw && have_w;

	always_comb
	begin
		next_state = state;
		next_have_aw = have_aw;
		next_have_w = have_w;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		case (state)
			PPDE_CH_IDLE:
			begin
				if (wr_commit)
				begin
					next_have_aw = 1'b0;
					next_have_w = 1'b0;
					next_bvalid = 1'b1;
					next_bresp = wr_ok ? `PPDE_RESP_OKAY : `PPDE_RESP_SLVERR;
					next_state = PPDE_CH_RESP;
				end
				else
				begin
					if (s_axi_awvalid && s_axi_awready)
					begin
						next_have_aw = 1'b1;
						next_wr_addr = s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready)
					begin
						next_have_w = 1'b1;
						next_wr_data = s_axi_wdata;
						next_wr_strb = s_axi_wstrb;
					end
				end
			end
			PPDE_CH_RESP:
			begin
				if (s_axi_bready)
				begin
					next_bvalid = 1'b0;
					next_state = PPDE_CH_IDLE;
				end
			end
			default:
			begin
				next_state = PPDE_CH_IDLE;
				next_have_aw = 1'b0;
				next_have_w = 1'b0;
				next_bvalid = 1'b0;
			end
		endcase
		next_awready = (next_state == PPDE_CH_IDLE) && !next_have_aw;
		next_wready = (next_state == PPDE_CH_IDLE) && !next_have_w;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= PPDE_CH_IDLE;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PPDE_RESP_OKAY;
		end
		else
		begin
			state <= next_state;
			have_aw <= next_have_aw;
			have_w <= next_have_w;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
		end
	end

endmodule // ppde_wr_chan

// ==== logic/ppde_rd_chan.sv ====
`timescale 1ns/1ps
`include "ppde_regs.svh"

module ppde_rd_chan
	import ppde_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite read channels
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side: value and decode for the address on the bus now
	input wire logic [31:0] rd_value,
	input wire logic rd_ok
);

	ppde_ch_state_t state, next_state;
	logic next_arready, next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	always_comb
	begin
		next_state = state;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		case (state)
			PPDE_CH_IDLE:
			begin
				if (s_axi_arvalid && s_axi_arready)
				begin
					// Unmapped reads answer zero with an error
					next_rdata = rd_ok ? rd_value : 32'h00000000;
					next_rresp = rd_ok ? `PPDE_RESP_OKAY : `PPDE_RESP_SLVERR;
					next_rvalid = 1'b1;
					next_state = PPDE_CH_RESP;
				end
			end
			PPDE_CH_RESP:
			begin
				if (s_axi_rready)
				begin
					next_rvalid = 1'b0;
					next_state = PPDE_CH_IDLE;
				end
			end
			default:
			begin
				next_state = PPDE_CH_IDLE;
				next_rvalid = 1'b0;
			end
		endcase
		next_arready = (next_state == PPDE_CH_IDLE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= PPDE_CH_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PPDE_RESP_OKAY;
		end
		else
		begin
			state <= next_state;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

endmodule // ppde_rd_chan

// ==== logic/ppde_top.sv ====
`timescale 1ns/1ps
`include "ppde_regs.svh"

module ppde_top
	import ppde_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pad controls
	output logic [3:0] g_drive_en,
	output logic [7:0] h_drive_en,
	output logic [7:0] a_sense_en,
	output logic [7:0] b_sense_en
);

	logic [7:0] port_g_output_enable, next_port_g_output_enable;
	logic [7:0] port_h_output_enable, next_port_h_output_enable;
	logic [7:0] port_a_input_enable, next_port_a_input_enable;
	logic [7:0] port_b_input_enable, next_port_b_input_enable;
	logic wr_commit;
	logic [15:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	ppde_sel_t wr_sel;
	ppde_sel_t rd_sel;
	logic [7:0] rd_byte;

	// Only the low byte lane carries a register; reserved bits never take a one
	function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
		return data & mask;
	endfunction

	assign wr_sel = ppde_decode(wr_addr);
	assign rd_sel = ppde_decode(s_axi_araddr);

	always_comb
	begin
		next_port_g_output_enable = port_g_output_enable;
		next_port_h_output_enable = port_h_output_enable;
		next_port_a_input_enable = port_a_input_enable;
		next_port_b_input_enable = port_b_input_enable;
		if (wr_commit && wr_strb[0])
		begin
			case (wr_sel)
				PPDE_SEL_G:
					next_port_g_output_enable = masked_write(wr_data[7:0], `PPDE_MASK_G);
				PPDE_SEL_H:
					next_port_h_output_enable = masked_write(wr_data[7:0], `PPDE_MASK_H);
				PPDE_SEL_A:
					next_port_a_input_enable = masked_write(wr_data[7:0], `PPDE_MASK_A);
				PPDE_SEL_B:
					next_port_b_input_enable = masked_write(wr_data[7:0], `PPDE_MASK_B);
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_g_output_enable <= `PPDE_RESET_G;
			port_h_output_enable <= `PPDE_RESET_H;
			port_a_input_enable <= `PPDE_RESET_A;
			port_b_input_enable <= `PPDE_RESET_B;
		end
		else
		begin
			port_g_output_enable <= next_port_g_output_enable;
			port_h_output_enable <= next_port_h_output_enable;
			port_a_input_enable <= next_port_a_input_enable;
			port_b_input_enable <= next_port_b_input_enable;
		end
	end

	// Read value is masked again so reserved bits stay zero even if a flop upsets
	always_comb
	begin
		case (rd_sel)
			PPDE_SEL_G:
				rd_byte = port_g_output_enable & `PPDE_MASK_G;
			PPDE_SEL_H:
				rd_byte = port_h_output_enable & `PPDE_MASK_H;
			PPDE_SEL_A:
				rd_byte = port_a_input_enable & `PPDE_MASK_A;
			PPDE_SEL_B:
				rd_byte = port_b_input_enable & `PPDE_MASK_B;
			default:
				rd_byte = 8'h00;
		endcase
	end

	// Pads follow the register flops directly
	assign g_drive_en = port_g_output_enable[3:0];
	assign h_drive_en = port_h_output_enable;
	assign a_sense_en = port_a_input_enable;
	assign b_sense_en = port_b_input_enable;

	ppde_wr_chan u_wr
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.wr_commit(wr_commit),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_sel != PPDE_SEL_NONE)
	);

	ppde_rd_chan u_rd
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rd_value({24'h000000, rd_byte}),
		.rd_ok(rd_sel != PPDE_SEL_NONE)
	);

endmodule // ppde_top

// ==== testbench/ppde_pad_model.sv ====
`timescale 1ns/1ps

module ppde_pad_model
(
	// Input enables from the block
	input wire logic [7:0] a_sense_en,
	input wire logic [7:0] b_sense_en,
	// Level on the pins
	input wire logic [7:0] pin_level,
	// What the input buffers pass on
	output logic [7:0] a_seen,
	output logic [7:0] b_seen
);
	// A disabled buffer passes a quiet low, never the pin
	assign a_seen = a_sense_en & pin_level;
	assign b_seen = b_sense_en & pin_level;
endmodule // ppde_pad_model

// ==== testbench/ppde_top_assertions.sv ====
`timescale 1ns/1ps

module ppde_top_assertions
	import ppde_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pad controls
	input wire logic [3:0] g_drive_en,
	input wire logic [7:0] h_drive_en,
	input wire logic [7:0] a_sense_en,
	input wire logic [7:0] b_sense_en
);
	logic [15:0] wa, ra;
	logic [7:0] wd;
	logic ws, aw_q, w_q;
	logic [31:0] pads_q, rd_exp;
	wire logic aw_hs = s_axi_awvalid && s_axi_awready;
	wire logic w_hs = s_axi_wvalid && s_axi_wready;
	// Later of the two write handshakes, in either order
	wire logic wr_go = (aw_hs || aw_q) && (w_hs || w_q) && !(aw_q && w_q);
	wire logic wa_map = wa inside {16'hc2d8, 16'hc2dc, 16'hc2e0, 16'hc2e4};
	wire logic rd_map = ra inside {16'hc2d8, 16'hc2dc, 16'hc2e0, 16'hc2e4};
	wire logic [31:0] pads = {4'h0, g_drive_en, h_drive_en, a_sense_en, b_sense_en};

	always_ff @(posedge aclk)
	begin
		pads_q <= pads;
		aw_q <= aresetn && !(s_axi_bvalid && s_axi_bready) && (aw_q || aw_hs);
		w_q <= aresetn && !(s_axi_bvalid && s_axi_bready) && (w_q || w_hs);
		if (aw_hs)
			wa <= s_axi_awaddr;
		if (w_hs)
		begin
			wd <= s_axi_wdata[7:0];
			ws <= s_axi_wstrb[0];
		end
		if (s_axi_arvalid && s_axi_arready)
			ra <= s_axi_araddr;
	end

	// Read data is the register value at the address handshake
	always_comb
	begin
		case (ra)
			16'hc2d8: rd_exp = {24'h0, pads_q[31:24]};
			16'hc2dc: rd_exp = {24'h0, pads_q[23:16]};
			16'hc2e0: rd_exp = {24'h0, pads_q[15:8]};
			16'hc2e4: rd_exp = {24'h0, pads_q[7:0]};
			default: rd_exp = 32'h0;
		endcase
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_rsv;
		h_drive_en[5:3] == 3'h0 && a_sense_en[4] == 1'b0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved pad enable set");
	property p_wr_lat;
		wr_go |-> !s_axi_bvalid [*2] ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
	property p_pad_src;
		!$stable(pads) && $past(aresetn) |-> $rose(s_axi_bvalid);
	endproperty
	a_pad_src: assert property (p_pad_src) else $error("pad changed without write");
	property p_wr_val;
		$rose(s_axi_bvalid) && ws |-> (wa != 16'hc2d8 || g_drive_en == wd[3:0])
			&& (wa != 16'hc2dc || h_drive_en == (wd & 8'hc7));
	endproperty
	a_wr_val: assert property (p_wr_val) else $error("written value not on pads");
	property p_bresp;
		$rose(s_axi_bvalid) |-> s_axi_bresp == (wa_map ? 2'b00 : 2'b10);
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response wrong");
	property p_rdata;
		$rose(s_axi_rvalid) |-> s_axi_rdata == rd_exp && s_axi_rresp == (rd_map ? 2'b00 : 2'b10);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read answer wrong");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read not closed");

	c_slverr: cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'b10);
	c_rd: cover property ($rose(s_axi_rvalid) && rd_map);
	c_h_all: cover property (h_drive_en == 8'hc7);
endmodule // ppde_top_assertions

bind ppde_top ppde_top_assertions i_chk (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .g_drive_en, .h_drive_en, .a_sense_en, .b_sense_en
);

// ==== testbench/tb_ppde_top.sv ====
`timescale 1ns/1ps

module tb_ppde_top
	import ppde_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [7:0] pin_level = 8'h96;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [3:0] g_drive_en;
	wire logic [7:0] h_drive_en, a_sense_en, b_sense_en, a_seen, b_seen;
	logic [7:0] pad [4];
	logic [7:0] want;
	logic [15:0] addr_t [4] = '{16'hc2d8, 16'hc2dc, 16'hc2e0, 16'hc2e4};
	logic [15:0] bad [3] = '{16'hc2d4, 16'hc2e8, 16'h30b7};
	logic [7:0] mask_t [4] = '{8'h0f, 8'hc7, 8'hef, 8'hff};
	logic [7:0] pat [3] = '{8'hff, 8'h5a, 8'h00};
	int num_errors = 0;
	int samples_checked = 0;

	ppde_top i_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .g_drive_en, .h_drive_en, .a_sense_en, .b_sense_en
	);
	ppde_pad_model i_pads (.a_sense_en, .b_sense_en, .pin_level, .a_seen, .b_seen);

	always_comb pad = '{{4'h0, g_drive_en}, h_drive_en, a_sense_en, b_sense_en};

	initial
	begin
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Each channel is released at its own handshake edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bready <= 1'b0;
				done = 1'b1;
				chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
			end
		end
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rready <= 1'b0;
				done = 1'b1;
				chk("rdata", s_axi_rdata, {24'h0, d});
				chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
			end
		end
	endtask

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 4; i++)
		begin
			rd(addr_t[i], 8'h00, 2'b00);
			chk("pad", {24'h0, pad[i]}, 32'h0);
		end
		$display("test reset done");
		foreach (bad[k])
		begin
			wr(bad[k], 8'hff, 4'h1, 2'b10);
			rd(bad[k], 8'h00, 2'b10);
		end
		wr(addr_t[0], 8'h0f, 4'he, 2'b00);
		for (int i = 0; i < 4; i++)
			chk("pad", {24'h0, pad[i]}, 32'h0);
		$display("test refused writes done");
		foreach (pat[j])
		begin
			for (int i = 0; i < 4; i++)
				wr(addr_t[i], pat[j] ^ 8'(i * 33), 4'h1, 2'b00);
			for (int i = 0; i < 4; i++)
			begin
				want = (pat[j] ^ 8'(i * 33)) & mask_t[i];
				chk("pad", {24'h0, pad[i]}, {24'h0, want});
				rd(addr_t[i], want, 2'b00);
			end
		end
		$display("test write readback done");
		wr(addr_t[2], 8'hff, 4'h1, 2'b00);
		wr(addr_t[3], 8'h0f, 4'h1, 2'b00);
		chk("a_seen", {24'h0, a_seen}, 32'h86);
		chk("b_seen", {24'h0, b_seen}, 32'h06);
		$display("test pad inputs done");
		wrap_up();
	end

	// About fourteen times the expected run
	initial
	begin
		#20000;
		num_errors++;
		wrap_up();
	end
endmodule // tb_ppde_top
